// ===== rtl/lfb_pkg.sv
// lfb_pkg: shared constants and types for the display frame and blink block
// assumes an 8-bit special function register port from the processor core
package lfb_pkg;

	// =====================================================================
	// register port
	// =====================================================================
	localparam int unsigned SFR_AW = 8;
	localparam int unsigned SFR_DW = 8;

	localparam logic [7:0] ADDR_CLK_BLINK = 8'h96;
	localparam logic [7:0] ADDR_LADDER = 8'h9C;
	localparam logic [7:0] ADDR_INV_UPD = 8'hB1;

	localparam logic [7:0] RST_CLK_BLINK = 8'h00;
	localparam logic [7:0] RST_LADDER = 8'h00;
	localparam logic [7:0] RST_INV_UPD = 8'h00;
	localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

	// =====================================================================
	// field positions
	// =====================================================================
	localparam int unsigned SRC_LSB = 6;
	localparam int unsigned RATE_LSB = 4;
	localparam int unsigned FD_LSB = 0;
	localparam int unsigned LADDER_BIT = 6;
	localparam int unsigned INV_BIT = 6;
	localparam int unsigned UPD_BIT = 1;
	localparam int unsigned HOLD_BIT = 0;

	// =====================================================================
	// modes
	// =====================================================================
	typedef enum logic [1:0] {
		SRC_SW_OFF = 2'b00,
		SRC_SW_ON = 2'b01,
		SRC_FIXED = 2'b10,
		SRC_RATE = 2'b11
	} lfb_blink_src_t;

	typedef enum logic [1:0] {
		MUX_RSVD = 2'b00,
		MUX_2 = 2'b01,
		MUX_3 = 2'b10,
		MUX_4 = 2'b11
	} lfb_mux_t;

	localparam logic DCLK_2048 = 1'b0;

	// =====================================================================
	// timing counts, in display clock ticks
	// =====================================================================
	// fast display clock: lowest setting and three-common cap
	localparam logic [7:0] DIV_LOW_2C = 8'h80;
	localparam logic [7:0] DIV_LOW_MC = 8'h40;
	localparam logic [7:0] DIV_CAP_3C = 8'h06;
	// slow display clock table
	localparam logic [7:0] S_DIV_TOP = 8'h01;
	localparam logic [7:0] S_DIV_ZERO = 8'h02;
	localparam logic [7:0] S_DIV_2C_N1 = 8'h04;
	localparam logic [7:0] S_DIV_2C_N2 = 8'h06;
	localparam logic [7:0] S_DIV_2C_REST = 8'h08;
	localparam logic [7:0] S_DIV_MC = 8'h04;
	// blink half periods in 128 Hz ticks: 2 Hz, and 1 Hz per rate step
	localparam logic [8:0] BLINK_HW_HALF = 9'h020;
	localparam logic [8:0] BLINK_RATE_UNIT = 9'h040;

endpackage : lfb_pkg

// ===== rtl/lfb_frame_timer.sv
// lfb_frame_timer: drive-frequency divider, common stepping, frame start
// assumes tick inputs are one-cycle pulses made on the same system clock
module lfb_frame_timer (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic tick_2048_i,
	input wire logic tick_128_i,
	input wire logic disp_clk_sel_i,
	input wire logic [1:0] common_count_sel_i,
	input wire logic [3:0] frame_div_sel_i,
	output logic [1:0] com_index_o,
	output logic frame_start_o
);
	import lfb_pkg::*;

	typedef struct packed {
		logic [7:0] cnt;
		logic [1:0] com;
		logic frame_start;
	} lfb_ft_state_t;

	lfb_ft_state_t st;
	lfb_ft_state_t next_st;
	logic [7:0] div;
	logic [1:0] last_com;
	logic tick;

	// =====================================================================
	// divisor decode
	// =====================================================================
	function automatic logic [7:0] lfb_divisor(input logic sel,
		input logic [1:0] mux, input logic [3:0] n);
		logic [7:0] d;
		d = S_DIV_MC;
		if (sel == DCLK_2048) begin
			if (n == 4'h0)
				d = (mux == MUX_2) ? DIV_LOW_2C : DIV_LOW_MC;
			else if (mux == MUX_2)
				d = 8'({4'h0, n} + 8'h01) << 2;
			else if (mux == MUX_3 && n == 4'h1)
				d = DIV_CAP_3C;
			else
				d = 8'({4'h0, n} + 8'h01) << 1;
		end else begin
			if (n == 4'hF)
				d = S_DIV_TOP;
			else if (n == 4'h0)
				d = S_DIV_ZERO;
			else if (mux == MUX_2 && n == 4'h1)
				d = S_DIV_2C_N1;
			else if (mux == MUX_2 && n == 4'h2)
				d = S_DIV_2C_N2;
			else if (mux == MUX_2)
				d = S_DIV_2C_REST;
		end
		return d;
	endfunction

	// clock source and common count decode
	always_comb begin
		div = lfb_divisor(disp_clk_sel_i, common_count_sel_i,
			frame_div_sel_i);
		tick = (disp_clk_sel_i == DCLK_2048) ? tick_2048_i
			: tick_128_i;
		case (common_count_sel_i)
			MUX_2: last_com = 2'h1;
			MUX_3: last_com = 2'h2;
			default: last_com = 2'h3; // reserved code runs as four commons
		endcase
	end

	// one drive period per common, frame ends after the last common
	always_comb begin
		next_st = st;
		next_st.frame_start = 1'b0;
		if (tick) begin
			if (st.cnt >= 8'(div - 8'h01)) begin
				next_st.cnt = 8'h00;
				if (st.com >= last_com) begin
					next_st.com = 2'h0;
					next_st.frame_start = 1'b1;
				end else begin
					next_st.com = 2'(st.com + 2'h1);
				end
			end else begin
				next_st.cnt = 8'(st.cnt + 8'h01);
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign com_index_o = st.com;
	assign frame_start_o = st.frame_start;

	// a common count lowered mid-frame wraps from above the new last common
	frame_len_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		frame_start_o |-> com_index_o == 2'h0
		&& $past(st.com) >= $past(last_com))
		else $error("frame started before the last common");

endmodule // lfb_frame_timer

// ===== rtl/lfb_blink_gen.sv
// lfb_blink_gen: display on/off pacing for the blink modes
// assumes tick_128_i is a one-cycle pulse at 128 Hz on the system clock
module lfb_blink_gen (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic tick_128_i,
	input wire logic blink_en_a_i,
	input wire logic [1:0] blink_source_i,
	input wire logic [1:0] blink_rate_sel_i,
	output logic display_on_o
);
	import lfb_pkg::*;

	typedef struct packed {
		logic [8:0] cnt;
		logic on;
	} lfb_bk_state_t;

	lfb_bk_state_t st;
	lfb_bk_state_t next_st;
	logic [8:0] half;

	// half period: fixed 2 Hz, or rate field steps of one second
	always_comb begin
		if (blink_source_i == SRC_FIXED)
			half = BLINK_HW_HALF;
		else
			half = 9'((9'({7'h00, blink_rate_sel_i}) + 9'h001)
				* BLINK_RATE_UNIT);
	end

	always_comb begin
		next_st = st;
		if (!blink_en_a_i) begin
			next_st.on = 1'b1;
			next_st.cnt = 9'h000;
		end else begin
			case (blink_source_i)
				SRC_SW_OFF: begin
					next_st.on = 1'b0;
					next_st.cnt = 9'h000;
				end
				SRC_SW_ON: begin
					next_st.on = 1'b1;
					next_st.cnt = 9'h000;
				end
				default: begin
					// hardware paced: fixed or rate-selected
					if (tick_128_i) begin
						if (st.cnt >= 9'(half - 9'h001)) begin
							next_st.cnt = 9'h000;
							next_st.on = ~st.on;
						end else begin
							next_st.cnt = 9'(st.cnt + 9'h001);
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st <= '{cnt: 9'h000, on: 1'b1};
		end else begin
			st <= next_st;
		end
	end

	assign display_on_o = st.on;

	blink_half_a: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i)
		(blink_en_a_i && blink_source_i[1] && $changed(st.on))
		|-> $past(st.cnt) == $past(half) - 9'h001)
		else $error("blink toggled off its half period");

endmodule // lfb_blink_gen

// ===== rtl/lfb_display_timing.sv
// lfb_display_timing: display frame timing, blink, inversion, data hold
// assumes the core's register port and tick pulses share clk_sys_i
//
// How it works
// - ladder select bit enables external bias ladder
// - inversion enable inverts every other frame
// - flag set when data taken, frame begun
// - hold bit stops loading from data registers
// - hold cleared: data applied from next frame
// - source 00 holds off, 01 holds on
// - source 10 blinks at fixed 2 Hz
// - source 11 uses the rate select field
// - rate codes: 1, 1/2, 1/3, 1/4 Hz
// - divider picks drive rate; frame = rate/commons
// - clock select: 0 fast clock, 1 slow
// - blink acts only while blink enabled
// - common count: 01 two, 10 three, 11 four
module lfb_display_timing (
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	// special function register port
	input wire logic [lfb_pkg::SFR_AW-1:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [lfb_pkg::SFR_DW-1:0] sfr_wdata_i,
	output logic [lfb_pkg::SFR_DW-1:0] sfr_rdata_o,
	// control bits held in the core's general configuration register
	input wire logic disp_clk_sel_i,
	input wire logic blink_en_a_i,
	input wire logic [1:0] common_count_sel_i,
	// display clock ticks
	input wire logic tick_2048_i,
	input wire logic tick_128_i,
	// toward the drive stage and the glass
	output logic ladder_en_o,
	output logic frame_invert_o,
	output logic display_on_o,
	output logic [1:0] com_index_o,
	output logic frame_start_o,
	output logic data_load_o,
	output logic data_hold_o,
	output logic update_done_o
);
	import lfb_pkg::*;

	// =====================================================================
	// state
	// =====================================================================
	typedef struct packed {
		logic [7:0] clk_cfg;
		logic ladder_sel;
		logic inv_en;
		logic inv_phase;
		logic hold;
		logic upd_done;
		logic upd_pend;
		logic data_load;
		logic [7:0] rdata;
	} lfb_top_state_t;

	lfb_top_state_t st;
	lfb_top_state_t next_st;

	logic wr_clk;
	logic wr_ladder;
	logic wr_inv;
	logic frame_start;
	logic [1:0] blink_source;
	logic [1:0] blink_rate_sel;
	logic [3:0] frame_div_sel;

	// =====================================================================
	// field views of the clock and blink register
	// =====================================================================
	assign blink_source = st.clk_cfg[SRC_LSB +: 2];
	assign blink_rate_sel = st.clk_cfg[RATE_LSB +: 2];
	assign frame_div_sel = st.clk_cfg[FD_LSB +: 4];

	// =====================================================================
	// address decode
	// =====================================================================
	always_comb begin
		wr_clk = 1'b0;
		wr_ladder = 1'b0;
		wr_inv = 1'b0;
		if (sfr_addr_i == ADDR_CLK_BLINK)
			wr_clk = sfr_wr_i;
		else if (sfr_addr_i == ADDR_LADDER)
			wr_ladder = sfr_wr_i;
		else if (sfr_addr_i == ADDR_INV_UPD)
			wr_inv = sfr_wr_i;
	end

	// read view; reserved bits read as zero whatever was written
	function automatic logic [7:0] lfb_read(input logic [7:0] addr,
		input lfb_top_state_t s);
		logic [7:0] r;
		r = RDATA_UNMAPPED;
		if (addr == ADDR_CLK_BLINK) begin
			r = s.clk_cfg;
		end else if (addr == ADDR_LADDER) begin
			r[LADDER_BIT] = s.ladder_sel;
		end else if (addr == ADDR_INV_UPD) begin
			r[INV_BIT] = s.inv_en;
			r[UPD_BIT] = s.upd_done;
			r[HOLD_BIT] = s.hold;
		end
		return r;
	endfunction

	// =====================================================================
	// next state
	// =====================================================================
	// frame events use the hold bit as it stood before any write in the
	// same cycle, so a frame never loads half-way through a hold change
	always_comb begin
		next_st = st;
		next_st.data_load = 1'b0;

		// register reads are captured so the read data comes from a flop
		if (sfr_rd_i)
			next_st.rdata = lfb_read(sfr_addr_i, st);

		// clock and blink configuration, all bits stored
		if (wr_clk)
			next_st.clk_cfg = sfr_wdata_i;

		// ladder select, reserved bits dropped
		if (wr_ladder)
			next_st.ladder_sel = sfr_wdata_i[LADDER_BIT];

		// inversion, hold and flag clear
		if (wr_inv) begin
			next_st.inv_en = sfr_wdata_i[INV_BIT];
			next_st.hold = sfr_wdata_i[HOLD_BIT];
			if (st.hold && !sfr_wdata_i[HOLD_BIT])
				next_st.upd_pend = 1'b1;
			if (!sfr_wdata_i[UPD_BIT])
				next_st.upd_done = 1'b0;
			if (!sfr_wdata_i[INV_BIT])
				next_st.inv_phase = 1'b0;
		end

		// frame boundary: inversion toggle, data take-up, flag set
		if (frame_start) begin
			if (st.inv_en && !(wr_inv && !sfr_wdata_i[INV_BIT]))
				next_st.inv_phase = ~st.inv_phase;
			if (!st.hold) begin
				next_st.data_load = 1'b1;
				if (st.upd_pend) begin
					// set wins over a clear written in the same cycle
					next_st.upd_done = 1'b1;
					next_st.upd_pend = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st <= '{clk_cfg: RST_CLK_BLINK,
				ladder_sel: RST_LADDER[LADDER_BIT],
				inv_en: RST_INV_UPD[INV_BIT],
				inv_phase: 1'b0,
				hold: RST_INV_UPD[HOLD_BIT],
				upd_done: RST_INV_UPD[UPD_BIT],
				upd_pend: 1'b0,
				data_load: 1'b0,
				rdata: RDATA_UNMAPPED};
		end else begin
			st <= next_st;
		end
	end

	// =====================================================================
	// timing engines
	// =====================================================================
	// frame divider and common stepping
	lfb_frame_timer u_frame_timer (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.tick_2048_i(tick_2048_i),
		.tick_128_i(tick_128_i),
		.disp_clk_sel_i(disp_clk_sel_i),
		.common_count_sel_i(common_count_sel_i),
		.frame_div_sel_i(frame_div_sel),
		.com_index_o(com_index_o),
		.frame_start_o(frame_start)
	);

	// blink pacing always runs from the slow tick, whatever the frame clock
	lfb_blink_gen u_blink_gen (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.tick_128_i(tick_128_i),
		.blink_en_a_i(blink_en_a_i),
		.blink_source_i(blink_source),
		.blink_rate_sel_i(blink_rate_sel),
		.display_on_o(display_on_o)
	);

	// =====================================================================
	// outputs
	// =====================================================================
	assign sfr_rdata_o = st.rdata;
	assign ladder_en_o = st.ladder_sel;
	assign frame_invert_o = st.inv_phase;
	assign frame_start_o = frame_start;
	assign data_load_o = st.data_load;
	assign data_hold_o = st.hold;
	assign update_done_o = st.upd_done;

	// =====================================================================
	// checks
	// =====================================================================
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_b_i);

	sequence s_ladder_write;
		wr_ladder;
	endsequence

	sequence s_hold_release;
		data_hold_o ##1 !data_hold_o;
	endsequence

	sequence s_armed_frame;
		frame_start && !data_hold_o && st.upd_pend;
	endsequence

	sequence s_frame_unheld;
		frame_start && !data_hold_o;
	endsequence

	ladder_follow_a: assert property (
		s_ladder_write |=> ladder_en_o == $past(sfr_wdata_i[LADDER_BIT]))
		else $error("ladder enable does not follow its bit");

	invert_off_a: assert property (
		!st.inv_en |-> !frame_invert_o)
		else $error("frame inverted while inversion disabled");

	invert_toggle_a: assert property (
		(frame_start && st.inv_en && !wr_inv)
		|=> frame_invert_o != $past(frame_invert_o))
		else $error("inversion did not toggle on frame start");

	update_arm_a: assert property (
		s_hold_release |-> st.upd_pend)
		else $error("hold release did not arm the update");

	update_set_a: assert property (
		s_armed_frame |=> update_done_o ##0 data_load_o)
		else $error("update flag not set after release and frame");

	update_sticky_a: assert property (
		(update_done_o && !(wr_inv && !sfr_wdata_i[UPD_BIT]))
		|=> update_done_o)
		else $error("update flag lost without a clearing write");

	hold_noload_a: assert property (
		(frame_start && data_hold_o) |=> !data_load_o)
		else $error("display loaded while data hold set");

	resume_load_a: assert property (
		s_frame_unheld |=> data_load_o [*1] ##1 !data_load_o)
		else $error("display not loaded at unheld frame start");

	blink_off_a: assert property (
		(blink_en_a_i && blink_source == SRC_SW_OFF) [*2]
		|-> !display_on_o)
		else $error("display on in software blink off mode");

	blink_on_a: assert property (
		(blink_en_a_i && blink_source == SRC_SW_ON) [*2]
		|-> display_on_o)
		else $error("display off in software blink on mode");

	blink_idle_a: assert property (
		!blink_en_a_i [*2] |-> display_on_o)
		else $error("display blanked with blink disabled");

	unmapped_read_a: assert property (
		(sfr_rd_i && sfr_addr_i != ADDR_CLK_BLINK
		&& sfr_addr_i != ADDR_LADDER && sfr_addr_i != ADDR_INV_UPD)
		|=> sfr_rdata_o == RDATA_UNMAPPED)
		else $error("unmapped read returned non-zero data");

endmodule // lfb_display_timing

// ===== testbench/lfb_glass_model.sv
// lfb_glass_model: stand-in for the segment glass on the common lines
// assumes frame_start_i is a one-cycle pulse on clk_sys_i
module lfb_glass_model (
	input wire logic clk_sys_i,
	input wire logic [1:0] com_index_i,
	input wire logic frame_start_i,
	input wire logic frame_invert_i,
	output int period_o,
	output int frames_o,
	output int com_top_o,
	output logic last_inv_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;
	int cmax;
	initial begin
		cnt = 0;
		cmax = 0;
		com_top_o = 0;
		period_o = 0;
		frames_o = 0;
		last_inv_o = 1'b0;
	end
	// =====================================================================
	// refresh watch
	// =====================================================================
	// glass sees frame edges and the common index: the gap between two frame edges is the refresh period
	always @(posedge clk_sys_i) begin
		cnt <= cnt + 1;
		if (frame_start_i === 1'b1) begin
			period_o <= cnt;
			cnt <= 1;
			frames_o <= frames_o + 1;
			last_inv_o <= frame_invert_i; // polarity of the frame just ended
			com_top_o <= cmax; // highest common driven in that frame
			cmax <= 0;
		end else if (int'(com_index_i) > cmax) begin
			cmax <= int'(com_index_i);
		end
	end
endmodule // lfb_glass_model

// ===== testbench/lfb_display_timing_tb.sv
// lfb_display_timing_tb: self-checking bench for the display timing block
// assumes scaled ticks: fast tick every 2 cycles, slow tick every 32
module lfb_display_timing_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import lfb_pkg::*;
	// =====================================================================
	// signals
	// =====================================================================
	logic clk_sys_i = 1'b0;
	logic rst_b_i = 1'b0;
	logic [7:0] sfr_addr_i = 8'h00;
	logic [7:0] sfr_wdata_i = 8'h00;
	logic [7:0] sfr_rdata_o;
	logic sfr_wr_i = 1'b0;
	logic sfr_rd_i = 1'b0;
	logic disp_clk_sel_i = 1'b0;
	logic blink_en_a_i = 1'b0;
	logic [1:0] common_count_sel_i = 2'b01;
	logic tick_2048_i = 1'b0;
	logic tick_128_i = 1'b0;
	logic ladder_en_o, frame_invert_o, display_on_o, frame_start_o;
	logic data_load_o, data_hold_o, update_done_o, last_inv, l0;
	logic [1:0] com_index_o;
	logic [7:0] v, w;
	int period, frames, fails = 0, num_checks = 0, cyc = 0, tc = 0;
	int loads = 0, a, c, n, slow, cm, com_top;
	logic [7:0] addrs[4] = '{ADDR_CLK_BLINK, ADDR_LADDER, ADDR_INV_UPD, 8'h95};

	lfb_display_timing i_dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
		.sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
		.sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
		.disp_clk_sel_i(disp_clk_sel_i), .blink_en_a_i(blink_en_a_i),
		.common_count_sel_i(common_count_sel_i), .tick_2048_i(tick_2048_i),
		.tick_128_i(tick_128_i), .ladder_en_o(ladder_en_o),
		.frame_invert_o(frame_invert_o), .display_on_o(display_on_o),
		.com_index_o(com_index_o), .frame_start_o(frame_start_o),
		.data_load_o(data_load_o), .data_hold_o(data_hold_o),
		.update_done_o(update_done_o));
	lfb_glass_model i_glass (.clk_sys_i(clk_sys_i), .com_index_i(com_index_o),
		.frame_start_i(frame_start_o), .frame_invert_i(frame_invert_o),
		.period_o(period), .frames_o(frames), .com_top_o(com_top),
		.last_inv_o(last_inv));

	// =====================================================================
	// clock, ticks, timeout
	// =====================================================================
	initial begin
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	// ticks scaled down so blink periods fit the run; ratio stays 16
	always @(negedge clk_sys_i) begin
		tc <= tc + 1;
		tick_2048_i <= (tc % 2 == 0);
		tick_128_i <= (tc % 32 == 0);
	end
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (data_load_o === 1'b1)
			loads <= loads + 1;
		if (cyc == 95000) begin
			fails++;
			final_report();
		end
	end

	// =====================================================================
	// model and tasks
	// =====================================================================
	// ticks per common step, from the divider tables
	function automatic int exp_d(input int sl, input int mx, input int nd);
		if (sl != 0) begin
			if (nd == 15)
				return 1;
			if (nd == 0)
				return 2;
			if (mx != 1)
				return 4;
			return (nd == 1) ? 4 : (nd == 2) ? 6 : 8;
		end
		if (nd == 0)
			return (mx == 1) ? 128 : 64;
		if (mx == 2 && nd == 1)
			return 6; // three commons capped
		return (mx == 1) ? 4 * (nd + 1) : 2 * (nd + 1);
	endfunction
	task automatic chk_val(input logic [7:0] g, input logic [7:0] e,
		input string m);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic chk_cnt(input int g, input int e, input string m);
		num_checks++;
		if (g != e) begin
			fails++;
			$display("MISMATCH t=%0t %s got %0d exp %0d", $time, m, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
		@(negedge clk_sys_i);
		sfr_addr_i = ad;
		sfr_wdata_i = dt;
		sfr_wr_i = 1'b1;
		@(negedge clk_sys_i);
		sfr_wr_i = 1'b0;
	endtask
	task automatic rd(input logic [7:0] ad, output logic [7:0] dt);
		@(negedge clk_sys_i);
		sfr_addr_i = ad;
		sfr_rd_i = 1'b1;
		@(negedge clk_sys_i);
		sfr_rd_i = 1'b0;
		dt = sfr_rdata_o;
	endtask
	task automatic wait_frames(input int k);
		int f0;
		f0 = frames;
		for (int i = 0; i < 20000 && frames < f0 + k; i++)
			@(negedge clk_sys_i);
	endtask
	// skip the first change, which may be a partial period
	task automatic meas_toggle(output int p);
		logic s;
		p = 0;
		s = display_on_o;
		for (int i = 0; i < 20000 && display_on_o === s; i++)
			@(negedge clk_sys_i);
		s = display_on_o;
		while (p < 20000 && display_on_o === s) begin
			@(negedge clk_sys_i);
			p++;
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// =====================================================================
	// tests
	// =====================================================================
	initial begin
		void'($urandom(32'h904B));
		repeat (10) @(negedge clk_sys_i);
		rst_b_i = 1'b1;
		foreach (addrs[i]) begin
			rd(addrs[i], v);
			chk_val(v, 8'h00, "reset read");
		end
		chk_val({3'h0, display_on_o, ladder_en_o, frame_invert_o,
			update_done_o, data_hold_o}, 8'h10, "reset outs");
		wr(ADDR_LADDER, 8'h40);
		chk_val({7'h0, ladder_en_o}, 8'h01, "ladder on");
		rd(ADDR_LADDER, v);
		chk_val(v, 8'h40, "ladder rb");
		wr(ADDR_LADDER, 8'h00);
		chk_val({7'h0, ladder_en_o}, 8'h00, "ladder off");
		w = 8'($urandom);
		wr(ADDR_CLK_BLINK, w);
		rd(ADDR_CLK_BLINK, v);
		chk_val(v, w, "clk rb");
		$display("test registers done");
		// every common count, both display clocks, cap case first
		for (int m = 0; m < 4; m++) begin
			for (int k = 0; k < 3; k++) begin
				n = (k == 0) ? 1 : $urandom_range(15, 0);
				slow = (k == 2);
				common_count_sel_i = m[1:0];
				disp_clk_sel_i = slow[0];
				wr(ADDR_CLK_BLINK, {4'h0, n[3:0]});
				wait_frames(3);
				cm = (m == 1) ? 2 : (m == 2) ? 3 : 4;
				chk_cnt(period, cm * exp_d(slow, m, n) * (slow ? 32 : 2),
					"frame period");
				chk_cnt(com_top, cm - 1, "commons");
			end
		end
		$display("test frame rate done");
		common_count_sel_i = 2'b01;
		disp_clk_sel_i = 1'b0;
		wr(ADDR_CLK_BLINK, 8'h01);
		wr(ADDR_INV_UPD, 8'h01);
		chk_val({7'h0, data_hold_o}, 8'h01, "hold set");
		// a frame that began just before the hold may still load once
		@(negedge clk_sys_i);
		a = loads;
		wait_frames(3);
		chk_cnt(loads - a, 0, "held loads");
		chk_val({7'h0, update_done_o}, 8'h00, "flag early");
		wr(ADDR_INV_UPD, 8'h00);
		for (int i = 0; i < 1000 && frame_start_o !== 1'b1; i++)
			@(negedge clk_sys_i);
		@(negedge clk_sys_i);
		chk_val({6'h0, data_load_o, update_done_o}, 8'h03, "resume");
		rd(ADDR_INV_UPD, v);
		chk_val(v, 8'h02, "flag rb");
		wr(ADDR_INV_UPD, 8'h00);
		chk_val({7'h0, update_done_o}, 8'h00, "flag clear");
		$display("test hold done");
		wr(ADDR_INV_UPD, 8'h40);
		wait_frames(2);
		l0 = last_inv;
		wait_frames(1);
		chk_val({7'h0, l0 ^ last_inv}, 8'h01, "invert alt");
		wr(ADDR_INV_UPD, 8'h00);
		wait_frames(2);
		chk_val({6'h0, frame_invert_o, last_inv}, 8'h00, "no invert");
		$display("test inversion done");
		blink_en_a_i = 1'b1;
		for (int s = 0; s < 2; s++) begin
			wr(ADDR_CLK_BLINK, {s[1:0], 6'h01});
			@(negedge clk_sys_i);
			chk_val({7'h0, display_on_o}, s[7:0], "sw blink");
		end
		wr(ADDR_CLK_BLINK, 8'h01);
		blink_en_a_i = 1'b0;
		repeat (2) @(negedge clk_sys_i);
		chk_val({7'h0, display_on_o}, 8'h01, "blink off");
		blink_en_a_i = 1'b1;
		wr(ADDR_CLK_BLINK, 8'h81);
		meas_toggle(c);
		chk_cnt(c, 32 * 32, "fixed blink");
		for (int r = 0; r < 4; r++) begin
			wr(ADDR_CLK_BLINK, {2'b11, r[1:0], 4'h1});
			meas_toggle(c);
			chk_cnt(c, 64 * (r + 1) * 32, "rate blink");
		end
		$display("test blink done");
		final_report();
	end
endmodule // lfb_display_timing_tb
